// >>> pss_pkg.sv
`default_nettype none
package pss_pkg;
  // register map
  localparam logic [7:0] PSS_CTRL_OFS = 8'h00;
  localparam logic [7:0] PSS_STATUS_OFS = 8'h04;
  localparam logic [7:0] PSS_ADDR_MASK = 8'hfc;
  localparam logic [31:0] PSS_CTRL_RESET = 32'h0000_0000;
  localparam logic [31:0] PSS_READ_ZERO = 32'h0000_0000;

  // control register fields
  localparam int PSS_CTRL_DETECT_BIT = 0;
  localparam int PSS_CTRL_CLK_RST_BIT = 1;
  localparam int PSS_CTRL_LOCK_RST_BIT = 2;
  localparam int PSS_CTRL_QWAKE_BIT = 3;
  localparam int PSS_CTRL_PLL_STOP_BIT = 4;
  localparam int PSS_CTRL_OSC_STOP_BIT = 5;
  localparam int PSS_CTRL_REFSEL_LSB = 6;

  // status register fields
  localparam int PSS_STAT_STICKY_BIT = 0;
  localparam int PSS_STAT_LOCK_BIT = 1;
  localparam int PSS_STAT_MISSING_BIT = 2;
  localparam int PSS_STAT_MODE_LSB = 4;

  // reference source encodings
  localparam logic [1:0] PSS_REF_CRYSTAL = 2'h0;
  localparam logic [1:0] PSS_REF_EXTERNAL = 2'h1;
  localparam logic [1:0] PSS_REF_ONE_TO_ONE = 2'h2;

  // loss event indices
  localparam int PSS_LOSS_LOCK = 0;
  localparam int PSS_LOSS_FB = 1;
  localparam int PSS_LOSS_REF = 2;
  localparam int PSS_LOSS_W = 3;

  // flag reset values
  localparam logic PSS_STICKY_RESET = 1'b0;
  localparam logic PSS_MISSING_RESET = 1'b0;

  typedef enum logic [2:0] {
    PSS_PLL_LOCKED_MODE,
    PSS_STOPPED,
    PSS_UNSTABLE,
    PSS_REF_FALLBACK,
    PSS_FREE_RUNNING_VCO_MODE,
    PSS_STUCK,
    PSS_RESET_HOLD
  } pss_mode_t;
endpackage
`default_nettype wire

// >>> pss_loss_latch.sv
`timescale 1ns/1ps
`default_nettype none
module pss_loss_latch
  import pss_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  // control
  input wire logic arm,
  input wire logic clear,
  input wire logic [PSS_LOSS_W-1:0] lost,
  // result
  output logic [PSS_LOSS_W-1:0] seen
);
  typedef struct packed {
    logic [PSS_LOSS_W-1:0] seen;
  } pss_latch_t;

  pss_latch_t r;
  pss_latch_t n;

  always_comb begin
    n = r;
    for (int i = 0; i < PSS_LOSS_W; i++) begin
      // set wins over clear
      if (arm && lost[i]) begin
        n.seen[i] = 1'b1;
      end else if (clear) begin
        n.seen[i] = 1'b0;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r <= '0;
    end else if (clk_en) begin
      r <= n;
    end
  end

  assign seen = r.seen;
endmodule
`default_nettype wire

// >>> pss_flag_keeper.sv
`timescale 1ns/1ps
`default_nettype none
module pss_flag_keeper
  import pss_pkg::*;
#(
  parameter logic RESET_VAL = 1'b0
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  // stop handling
  input wire logic snap,
  input wire logic force_on,
  input wire logic force_val,
  input wire logic release_on,
  input wire logic restore,
  // run-time updates, hardware before software
  input wire logic hw_upd,
  input wire logic hw_val,
  input wire logic sw_wr,
  input wire logic sw_val,
  // flag
  output logic val
);
  typedef struct packed {
    logic val;
    logic pre;
  } pss_keep_t;

  pss_keep_t r;
  pss_keep_t n;

  always_comb begin
    n = r;
    if (snap) begin
      n.pre = r.val;
    end
    if (force_on) begin
      n.val = force_val;
    end else if (release_on) begin
      n.val = restore ? r.pre : r.val;
    end else if (hw_upd) begin
      n.val = hw_val;
    end else if (sw_wr) begin
      n.val = sw_val;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r.val <= RESET_VAL;
      r.pre <= RESET_VAL;
    end else if (clk_en) begin
      r <= n;
    end
  end

  assign val = r.val;
endmodule
`default_nettype wire

// >>> pss_supervisor.sv
`timescale 1ns/1ps
`default_nettype none
module pss_supervisor
  import pss_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // pll and clock monitors
  input wire logic pll_lock,
  input wire logic fb_clk_ok,
  input wire logic ref_clk_ok,
  // power sequencing
  input wire logic stop_req,
  input wire logic wake_req,
  // clock generator controls
  output logic pll_run,
  output logic osc_run,
  output logic [2:0] clock_mode,
  output logic chip_reset_req
);
  typedef struct packed {
    pss_mode_t mode;
    logic missing_clock_detect_enable;
    logic missing_clock_reset_enable;
    logic phase_loss_reset_enable;
    logic quick_wake_enable;
    logic pll_in_stop;
    logic stop_clock_select;
    logic [1:0] ref_select;
    logic restore_sticky;
    logic restore_missing;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic pll_run;
    logic osc_run;
    logic rst_req;
  } pss_state_t;

  function automatic logic reg_hit(input logic [7:0] addr,
                                   input logic [7:0] ofs);
    reg_hit = ((addr & PSS_ADDR_MASK) == ofs);
  endfunction

  pss_state_t r;
  pss_state_t n;

  // flag keeper controls
  logic snap;
  logic st_force;
  logic st_force_val;
  logic st_release;
  logic st_hw;
  logic st_sw;
  logic ms_force;
  logic ms_force_val;
  logic ms_release;
  logic ms_hw;
  logic ms_sw;
  logic sticky_flag;
  logic missing_flag;

  // loss tracking
  logic loss_arm;
  logic [PSS_LOSS_W-1:0] loss_now;
  logic [PSS_LOSS_W-1:0] loss_seen;

  // decode
  logic crystal;
  logic osc_in_stop;
  logic clock_lost;
  logic clk_rst;
  logic access;
  logic wr_ctrl;
  logic wr_status;

  always_comb begin
    n = r;
    snap = 1'b0;
    st_force = 1'b0;
    st_force_val = 1'b0;
    st_release = 1'b0;
    st_hw = 1'b0;
    st_sw = 1'b0;
    ms_force = 1'b0;
    ms_force_val = 1'b0;
    ms_release = 1'b0;
    ms_hw = 1'b0;
    ms_sw = 1'b0;

    crystal = (r.ref_select == PSS_REF_CRYSTAL);
    // non-crystal sources act as oscillator on in stop
    osc_in_stop = crystal ? r.stop_clock_select : 1'b1;
    clock_lost = !fb_clk_ok || !ref_clk_ok;
    clk_rst = r.missing_clock_detect_enable &&
              r.missing_clock_reset_enable;
    loss_now = {!ref_clk_ok, !fb_clk_ok, !pll_lock};
    loss_arm = (r.mode == PSS_STOPPED);

    // apb: one wait state, then answer
    access = psel && penable && r.pready;
    wr_ctrl = access && pwrite && reg_hit(paddr, PSS_CTRL_OFS);
    wr_status = access && pwrite && reg_hit(paddr, PSS_STATUS_OFS);
    n.pready = psel && penable && !r.pready;
    n.pslverr = 1'b0;
    n.prdata = PSS_READ_ZERO;
    if (psel && penable && !r.pready) begin
      if (reg_hit(paddr, PSS_CTRL_OFS)) begin
        n.prdata[PSS_CTRL_DETECT_BIT] = r.missing_clock_detect_enable;
        n.prdata[PSS_CTRL_CLK_RST_BIT] = r.missing_clock_reset_enable;
        n.prdata[PSS_CTRL_LOCK_RST_BIT] = r.phase_loss_reset_enable;
        n.prdata[PSS_CTRL_QWAKE_BIT] = r.quick_wake_enable;
        n.prdata[PSS_CTRL_PLL_STOP_BIT] = r.pll_in_stop;
        n.prdata[PSS_CTRL_OSC_STOP_BIT] = r.stop_clock_select;
        n.prdata[PSS_CTRL_REFSEL_LSB +: 2] = r.ref_select;
      end else if (reg_hit(paddr, PSS_STATUS_OFS)) begin
        n.prdata[PSS_STAT_STICKY_BIT] = sticky_flag;
        n.prdata[PSS_STAT_LOCK_BIT] = pll_lock;
        n.prdata[PSS_STAT_MISSING_BIT] = missing_flag;
        n.prdata[PSS_STAT_MODE_LSB +: 3] = r.mode;
      end else begin
        n.pslverr = 1'b1;
      end
    end
    if (wr_ctrl) begin
      n.missing_clock_detect_enable = pwdata[PSS_CTRL_DETECT_BIT];
      n.missing_clock_reset_enable = pwdata[PSS_CTRL_CLK_RST_BIT];
      n.phase_loss_reset_enable = pwdata[PSS_CTRL_LOCK_RST_BIT];
      n.quick_wake_enable = pwdata[PSS_CTRL_QWAKE_BIT];
      n.pll_in_stop = pwdata[PSS_CTRL_PLL_STOP_BIT];
      n.stop_clock_select = pwdata[PSS_CTRL_OSC_STOP_BIT];
      n.ref_select = pwdata[PSS_CTRL_REFSEL_LSB +: 2];
    end
    // sticky flag: write one rearms from current lock
    st_sw = wr_status && pwdata[PSS_STAT_STICKY_BIT];
    // missing status: write one clears
    ms_sw = wr_status && pwdata[PSS_STAT_MISSING_BIT];

    unique case (r.mode)
      PSS_PLL_LOCKED_MODE: begin
        n.pll_run = 1'b1;
        n.osc_run = crystal;
        st_hw = !pll_lock;
        ms_hw = r.missing_clock_detect_enable && clock_lost;
        if (r.phase_loss_reset_enable && !pll_lock) begin
          n.mode = PSS_RESET_HOLD;
        end else if (clk_rst && clock_lost) begin
          n.mode = PSS_RESET_HOLD;
        end else if (r.missing_clock_detect_enable && !ref_clk_ok) begin
          n.mode = PSS_FREE_RUNNING_VCO_MODE;
          st_force = 1'b1;
          ms_force = 1'b1;
          ms_force_val = 1'b1;
        end else if (r.missing_clock_detect_enable && !fb_clk_ok) begin
          n.mode = PSS_REF_FALLBACK;
          st_force = 1'b1;
          ms_force = 1'b1;
          ms_force_val = 1'b1;
        end else if (stop_req) begin
          if (!r.pll_in_stop &&
              (r.phase_loss_reset_enable || clk_rst)) begin
            n.mode = PSS_RESET_HOLD;
          end else begin
            n.mode = PSS_STOPPED;
            snap = 1'b1;
            n.restore_sticky = 1'b1;
            n.restore_missing = 1'b1;
            n.pll_run = r.pll_in_stop;
            n.osc_run = crystal && osc_in_stop;
          end
        end
      end
      PSS_STOPPED: begin
        if (r.pll_in_stop && r.phase_loss_reset_enable &&
            (!pll_lock || clock_lost)) begin
          n.mode = PSS_RESET_HOLD;
        end else if (r.pll_in_stop && clk_rst && clock_lost) begin
          n.mode = PSS_RESET_HOLD;
        end else if (wake_req) begin
          n.pll_run = 1'b1;
          n.osc_run = crystal;
          if (r.missing_clock_detect_enable && osc_in_stop &&
              loss_seen[PSS_LOSS_REF]) begin
            n.mode = PSS_FREE_RUNNING_VCO_MODE;
            st_force = 1'b1;
            ms_force = 1'b1;
            ms_force_val = 1'b1;
          end else if (r.pll_in_stop) begin
            if (r.missing_clock_detect_enable &&
                loss_seen[PSS_LOSS_FB]) begin
              n.mode = PSS_REF_FALLBACK;
              st_force = 1'b1;
              ms_force = 1'b1;
              ms_force_val = 1'b1;
            end else if (|loss_seen) begin
              // a loss was seen in stop, pre-stop sticky value is gone
              n.restore_sticky = 1'b0;
              st_force = 1'b1;
              if (pll_lock && !clock_lost) begin
                n.mode = PSS_PLL_LOCKED_MODE;
                ms_release = 1'b1;
              end else if (r.quick_wake_enable && !clock_lost) begin
                n.mode = PSS_UNSTABLE;
              end else begin
                n.mode = PSS_STUCK;
              end
            end else begin
              n.mode = PSS_PLL_LOCKED_MODE;
              st_release = 1'b1;
              ms_release = 1'b1;
            end
          end else begin
            // pll was off: lock comes back later
            st_force = 1'b1;
            if (r.missing_clock_detect_enable &&
                loss_seen[PSS_LOSS_REF]) begin
              ms_force = 1'b1;
              ms_force_val = 1'b1;
              n.mode = PSS_STUCK;
            end else if (r.quick_wake_enable && fb_clk_ok) begin
              n.mode = PSS_UNSTABLE;
            end else begin
              n.mode = PSS_STUCK;
            end
          end
        end
      end
      PSS_UNSTABLE: begin
        if (r.phase_loss_reset_enable && clock_lost) begin
          n.mode = PSS_RESET_HOLD;
        end else if (clk_rst && clock_lost) begin
          n.mode = PSS_RESET_HOLD;
        end else if (pll_lock) begin
          n.mode = PSS_PLL_LOCKED_MODE;
          st_release = 1'b1;
          ms_release = 1'b1;
        end
      end
      PSS_STUCK: begin
        if (r.phase_loss_reset_enable && pll_lock && !clock_lost) begin
          n.mode = PSS_PLL_LOCKED_MODE;
          st_release = 1'b1;
          ms_release = 1'b1;
        end else if (pll_lock && !clock_lost) begin
          n.mode = PSS_PLL_LOCKED_MODE;
          st_release = 1'b1;
          ms_release = 1'b1;
        end else if (r.quick_wake_enable && !clock_lost) begin
          n.mode = PSS_UNSTABLE;
        end
      end
      PSS_REF_FALLBACK: begin
        // no lock expected: flags hold until software writes
        if (r.missing_clock_detect_enable && !ref_clk_ok) begin
          n.mode = PSS_STUCK;
        end
      end
      PSS_FREE_RUNNING_VCO_MODE: begin
        // stays self-clocked, flags hold until software writes
        n.pll_run = 1'b1;
      end
      PSS_RESET_HOLD: begin
        n.rst_req = 1'b1;
      end
      default: begin
        n.mode = PSS_RESET_HOLD;
      end
    endcase
    if (n.mode == PSS_RESET_HOLD) begin
      n.rst_req = 1'b1;
    end
    // missing status is only raised when detection is on
    if (ms_force && !r.missing_clock_detect_enable) begin
      ms_force = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r.mode <= PSS_PLL_LOCKED_MODE;
      r.missing_clock_detect_enable <= PSS_CTRL_RESET[PSS_CTRL_DETECT_BIT];
      r.missing_clock_reset_enable <= PSS_CTRL_RESET[PSS_CTRL_CLK_RST_BIT];
      r.phase_loss_reset_enable <= PSS_CTRL_RESET[PSS_CTRL_LOCK_RST_BIT];
      r.quick_wake_enable <= PSS_CTRL_RESET[PSS_CTRL_QWAKE_BIT];
      r.pll_in_stop <= PSS_CTRL_RESET[PSS_CTRL_PLL_STOP_BIT];
      r.stop_clock_select <= PSS_CTRL_RESET[PSS_CTRL_OSC_STOP_BIT];
      r.ref_select <= PSS_CTRL_RESET[PSS_CTRL_REFSEL_LSB +: 2];
      r.restore_sticky <= 1'b1;
      r.restore_missing <= 1'b1;
      r.pready <= 1'b0;
      r.pslverr <= 1'b0;
      r.prdata <= PSS_READ_ZERO;
      r.pll_run <= 1'b1;
      r.osc_run <= 1'b1;
      r.rst_req <= 1'b0;
    end else if (clk_en) begin
      r <= n;
    end
  end

  pss_loss_latch u_loss (
    .pclk(pclk),
    .presetn(presetn),
    .clk_en(clk_en),
    .arm(loss_arm),
    .clear(snap),
    .lost(loss_now),
    .seen(loss_seen)
  );

  pss_flag_keeper #(
    .RESET_VAL(PSS_STICKY_RESET)
  ) u_sticky (
    .pclk(pclk),
    .presetn(presetn),
    .clk_en(clk_en),
    .snap(snap),
    .force_on(st_force),
    .force_val(st_force_val),
    .release_on(st_release),
    .restore(r.restore_sticky),
    .hw_upd(st_hw),
    .hw_val(1'b0),
    .sw_wr(st_sw),
    .sw_val(pll_lock),
    .val(sticky_flag)
  );

  pss_flag_keeper #(
    .RESET_VAL(PSS_MISSING_RESET)
  ) u_missing (
    .pclk(pclk),
    .presetn(presetn),
    .clk_en(clk_en),
    .snap(snap),
    .force_on(ms_force),
    .force_val(ms_force_val),
    .release_on(ms_release),
    .restore(r.restore_missing),
    .hw_upd(ms_hw),
    .hw_val(1'b1),
    .sw_wr(ms_sw),
    .sw_val(1'b0),
    .val(missing_flag)
  );

  assign prdata = r.prdata;
  assign pready = r.pready;
  assign pslverr = r.pslverr;
  assign pll_run = r.pll_run;
  assign osc_run = r.osc_run;
  assign clock_mode = r.mode;
  assign chip_reset_req = r.rst_req;
endmodule
`default_nettype wire

// >>> pss_supervisor_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module pss_supervisor_asserts (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // monitors and sequencing
  input wire logic pll_lock,
  input wire logic fb_clk_ok,
  input wire logic ref_clk_ok,
  input wire logic stop_req,
  input wire logic wake_req,
  // clock generator
  input wire logic pll_run,
  input wire logic [2:0] clock_mode,
  input wire logic chip_reset_req
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_apb_wait_state: assert property (clk_en && psel && penable && !pready
    |=> pready) else $error("access not answered after one wait");
  a_ready_single: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  a_err_no_data: assert property (pslverr |-> pready && prdata == 32'h0)
    else $error("error without ready or with data");
  a_stop_entry: assert property (
    clk_en && clock_mode == 3'h0 && stop_req
    |=> clock_mode inside {3'h1, 3'h6})
    else $error("stop request not taken");
  a_stop_hold: assert property (
    clk_en && clock_mode == 3'h1 && !wake_req
    |=> clock_mode inside {3'h1, 3'h6})
    else $error("left stop without wake");
  a_wake_leaves: assert property (
    clk_en && clock_mode == 3'h1 && wake_req |=> clock_mode != 3'h1)
    else $error("wake ignored in stop");
  a_reset_hold: assert property (
    clock_mode == 3'h6 |=> (clock_mode == 3'h6 && chip_reset_req) [*2])
    else $error("reset hold not kept");
  a_frozen_state: assert property (!clk_en |=> $stable(clock_mode)
    && $stable(pll_run) && $stable(chip_reset_req))
    else $error("state moved while disabled");
  a_stuck_exit: assert property (
    clk_en && clock_mode == 3'h5 && pll_lock && fb_clk_ok && ref_clk_ok
    |=> clock_mode == 3'h0) else $error("stuck not left on lock");
  a_stuck_wait: assert property (
    clk_en && clock_mode == 3'h5 && !pll_lock && !fb_clk_ok
    |=> clock_mode == 3'h5) else $error("stuck left without lock");
  a_unstable_exit: assert property (
    clk_en && clock_mode == 3'h2 && pll_lock && fb_clk_ok && ref_clk_ok
    |=> clock_mode == 3'h0) else $error("unstable not left on lock");
endmodule

bind pss_supervisor pss_supervisor_asserts pss_supervisor_asserts_inst (
  .pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel),
  .penable(penable), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .pll_lock(pll_lock), .fb_clk_ok(fb_clk_ok), .ref_clk_ok(ref_clk_ok),
  .stop_req(stop_req), .wake_req(wake_req), .pll_run(pll_run),
  .clock_mode(clock_mode), .chip_reset_req(chip_reset_req));
`default_nettype wire

// >>> tb_pll_stop_mode_supervisor.sv
`timescale 1ns/1ps
`default_nettype none
module tb_pll_stop_mode_supervisor;
  import pss_pkg::*;
  typedef struct {
    logic [7:0] c;
    logic lk;
    logic fb;
    logic rf;
    logic [2:0] md;
    logic [2:0] st;
    logic rs;
    logic sk;
  } pss_row_t;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic clk_en = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic pll_lock = 1'b1;
  logic fb_clk_ok = 1'b1;
  logic ref_clk_ok = 1'b1;
  logic stop_req = 1'b0;
  logic wake_req = 1'b0;
  logic pll_run;
  logic osc_run;
  logic [2:0] clock_mode;
  logic chip_reset_req;
  int failures = 0;
  int n_compared = 0;
  logic [31:0] rd;
  logic er;
  // ctrl, levels in stop, wake mode, flags (7 skips), regain check, sticky
  pss_row_t rows [13] = '{
    '{8'h31, 1, 1, 1, 3'h0, 3'b011, 1, 1},
    '{8'h31, 0, 0, 1, 3'h3, 3'b100, 0, 0},
    '{8'h31, 0, 1, 0, 3'h4, 3'b100, 0, 0},
    '{8'h39, 0, 1, 1, 3'h2, 3'b000, 1, 0},
    '{8'h31, 0, 1, 1, 3'h5, 3'b000, 1, 0},
    '{8'h29, 0, 1, 1, 3'h2, 3'b000, 1, 1},
    '{8'h29, 0, 0, 1, 3'h5, 3'b111, 0, 0},
    '{8'h33, 0, 0, 1, 3'h6, 3'b111, 0, 0},
    '{8'h34, 0, 1, 1, 3'h6, 3'b111, 0, 0},
    '{8'h24, 1, 1, 1, 3'h6, 3'b111, 0, 0},
    '{8'h70, 1, 1, 1, 3'h0, 3'b011, 1, 1},
    '{8'hb0, 1, 1, 1, 3'h0, 3'b011, 1, 1},
    '{8'h10, 1, 1, 1, 3'h0, 3'b011, 1, 1}};

  pss_supervisor pss_supervisor_inst (
    .pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pll_lock(pll_lock), .fb_clk_ok(fb_clk_ok), .ref_clk_ok(ref_clk_ok),
    .stop_req(stop_req), .wake_req(wake_req), .pll_run(pll_run),
    .osc_run(osc_run), .clock_mode(clock_mode),
    .chip_reset_req(chip_reset_req));

  always #20 pclk = ~pclk;

  task wrap_up();
    $display("compared %0d mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
    n_compared++;
    if (got !== ex) begin
      $display("[ERR] %s expected %h seen %h", nm, ex, got);
      failures++;
    end
  endtask

  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20) begin
      failures++;
      wrap_up();
    end
  endtask

  task rst(input int n);
    presetn <= 1'b0;
    pll_lock <= 1'b1;
    fb_clk_ok <= 1'b1;
    ref_clk_ok <= 1'b1;
    repeat (n) @(posedge pclk);
    chk("reset mode", 3'h0, clock_mode);
    chk("reset request", 1'b0, chip_reset_req);
    presetn <= 1'b1;
  endtask

  task stop_now();
    stop_req <= 1'b1;
    @(posedge pclk);
    stop_req <= 1'b0;
  endtask

  task run_row(input pss_row_t r);
    rst(2);
    apb(1'b1, PSS_CTRL_OFS, {24'h0, r.c});
    apb(1'b1, PSS_STATUS_OFS, 32'h1);
    stop_now();
    @(posedge pclk);
    chk("stop mode", (!r.c[4] && (r.c[2] || (r.c[0] && r.c[1])))
      ? 3'h6 : 3'h1, clock_mode);
    if (clock_mode === 3'h1) begin
      chk("pll in stop", r.c[4], pll_run);
      chk("osc in stop", r.c[5] && r.c[7:6] == PSS_REF_CRYSTAL,
        osc_run);
    end
    pll_lock <= r.lk & pll_run;
    fb_clk_ok <= r.fb & pll_run;
    ref_clk_ok <= r.rf;
    repeat (2) @(posedge pclk);
    fb_clk_ok <= r.fb;
    wake_req <= 1'b1;
    @(posedge pclk);
    wake_req <= 1'b0;
    @(posedge pclk);
    chk("wake mode", r.md, clock_mode);
    chk("reset request", r.md == 3'h6, chip_reset_req);
    if (r.st != 3'h7) begin
      apb(1'b0, PSS_STATUS_OFS, 32'h0);
      chk("wake flags", r.st, rd[2:0]);
      chk("mode field", r.md, rd[6:4]);
    end
    if (r.rs) begin
      pll_lock <= 1'b1;
      fb_clk_ok <= 1'b1;
      ref_clk_ok <= 1'b1;
      repeat (3) @(posedge pclk);
      chk("regain mode", 3'h0, clock_mode);
      apb(1'b0, PSS_STATUS_OFS, 32'h0);
      chk("regain sticky", r.sk, rd[PSS_STAT_STICKY_BIT]);
    end
  endtask

  initial begin
    rst(5);
    chk("pll after reset", 1'b1, pll_run);
    chk("osc after reset", 1'b1, osc_run);
    chk("ready after reset", 1'b0, pready);
    apb(1'b0, PSS_CTRL_OFS, 32'h0);
    chk("ctrl reset", PSS_CTRL_RESET, rd);
    apb(1'b0, PSS_STATUS_OFS, 32'h0);
    chk("status reset", 32'h2, rd);
    apb(1'b1, PSS_CTRL_OFS, 32'h7b);
    apb(1'b1, 8'h08, 32'hffff_ffff);
    chk("unmapped write err", 1'b1, er);
    apb(1'b0, 8'h08, 32'h0);
    chk("unmapped read err", 1'b1, er);
    chk("unmapped read data", 32'h0, rd);
    apb(1'b0, PSS_CTRL_OFS, 32'h0);
    chk("ctrl readback", 32'h7b, rd);
    foreach (rows[i]) run_row(rows[i]);
    rst(2);
    apb(1'b1, PSS_CTRL_OFS, 32'h31);
    stop_now();
    clk_en <= 1'b0;
    wake_req <= 1'b1;
    repeat (3) @(posedge pclk);
    wake_req <= 1'b0;
    clk_en <= 1'b1;
    repeat (2) @(posedge pclk);
    chk("frozen stop", 3'h1, clock_mode);
    wake_req <= 1'b1;
    @(posedge pclk);
    wake_req <= 1'b0;
    @(posedge pclk);
    chk("late wake", 3'h0, clock_mode);
    rst(2);
    apb(1'b1, PSS_CTRL_OFS, 32'h1);
    fb_clk_ok <= 1'b0;
    repeat (2) @(posedge pclk);
    chk("run fb loss", 3'h3, clock_mode);
    apb(1'b0, PSS_STATUS_OFS, 32'h0);
    chk("fallback flags", 3'b110, rd[2:0]);
    apb(1'b1, PSS_STATUS_OFS, 32'h4);
    apb(1'b0, PSS_STATUS_OFS, 32'h0);
    chk("missing cleared", 1'b0, rd[PSS_STAT_MISSING_BIT]);
    ref_clk_ok <= 1'b0;
    repeat (2) @(posedge pclk);
    chk("fallback ref loss", 3'h5, clock_mode);
    pll_lock <= 1'b0;
    repeat (2) @(posedge pclk);
    chk("stuck no lock", 3'h5, clock_mode);
    pll_lock <= 1'b1;
    fb_clk_ok <= 1'b1;
    ref_clk_ok <= 1'b1;
    repeat (2) @(posedge pclk);
    chk("stuck exit", 3'h0, clock_mode);
    wrap_up();
  end
endmodule
`default_nettype wire
